/* File: common/uv_ctrl_pkg.sv */
package uv_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] LEVEL_CTRL_OFFSET    = 8'h01;
  localparam logic [7:0] MONITOR_LEVEL_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CONTROL_OFFSET   = 8'h09;
  localparam logic [7:0] IRQ_FLAG_OFFSET      = 8'h0A;
  localparam logic [7:0] MONITOR_STATUS_OFFSET = 8'h0B;
  localparam logic [7:0] CHANGE_GUARD_OFFSET  = 8'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SLEEP_MODE_LSB    = 0;
  localparam int ACTIVE_MODE_LSB   = 2;
  localparam int SAMPLE_RATE_BIT   = 4;
  localparam int IRQ_ENABLE_BIT    = 0;
  localparam int TRIGGER_LSB       = 1;
  localparam int IRQ_FLAG_BIT      = 0;
  localparam int STATUS_BIT        = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MARGIN_RESET  = 2'h0;
  localparam logic [1:0] TRIGGER_RESET = 2'h0;
  localparam logic [2:0] LEVEL_RESET   = 3'h0;
  localparam logic [1:0] MODE_RESET    = 2'h0;

  // arbitrary neutral value for the unlock key
  localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5A;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned FAST_PERIOD_US    = 1000;
  localparam int unsigned SLOW_PERIOD_US    = 8000;
  localparam int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_US * CLK_MHZ;
  localparam int unsigned SLOW_PERIOD_CYCLES = SLOW_PERIOD_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYCLES     = 4;
  localparam int unsigned UNLOCK_WINDOW     = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DISABLED   = 2'b00,
    MODE_CONTINUOUS = 2'b01,
    MODE_SAMPLED    = 2'b10,
    MODE_WAKE_HOLD  = 2'b11
  } det_mode_type;

  typedef enum logic [1:0] {
    TRIG_FALLING = 2'b00,
    TRIG_RISING  = 2'b01,
    TRIG_EITHER  = 2'b10,
    TRIG_RSVD    = 2'b11
  } trigger_type;

  typedef enum logic {
    SEQ_WAIT   = 1'b0,
    SEQ_SETTLE = 1'b1
  } seq_state_type;

  typedef struct packed {
    logic       sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] level;
  } detector_fuse_byte_type;

  typedef struct packed {
    logic undervoltage_below;
    logic warning_below;
  } comparator_type;

endpackage

/* File: design/undervoltage_mode_and_early_warning_ctrl.sv */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module undervoltage_mode_and_early_warning_ctrl #(
  parameter int unsigned FAST_PERIOD_CYCLES = uv_ctrl_pkg::FAST_PERIOD_CYCLES,
  parameter int unsigned SLOW_PERIOD_CYCLES = uv_ctrl_pkg::SLOW_PERIOD_CYCLES,
  parameter logic [7:0]  UNLOCK_KEY         = uv_ctrl_pkg::UNLOCK_KEY_DEFAULT
) (
  // clock and reset
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_reset,
  input  wire logic                                i_clk_en,
  // register port
  input  wire logic [7:0]                          i_reg_addr,
  input  wire logic [7:0]                          i_reg_wdata,
  input  wire logic                                i_reg_write,
  input  wire logic                                i_reg_read,
  output logic [7:0]                               o_reg_rdata,
  // fuses and system state
  input  wire uv_ctrl_pkg::detector_fuse_byte_type i_fuses,
  input  wire logic                                i_deep_sleep,
  input  wire logic                                i_debug_halt,
  // analog comparators
  input  wire uv_ctrl_pkg::comparator_type         i_comparators,
  output logic                                     o_detector_power,
  output logic [2:0]                               o_threshold_level,
  output logic [1:0]                               o_monitor_margin,
  // system requests
  output logic                                     o_reset_request,
  output logic                                     o_wake_hold,
  output logic                                     o_irq
);

  localparam int CNT_W = $clog2(SLOW_PERIOD_CYCLES + 1);
  localparam logic [CNT_W-1:0] FAST_RELOAD = CNT_W'(FAST_PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLOW_RELOAD = CNT_W'(SLOW_PERIOD_CYCLES - 1);
  localparam logic [2:0] SETTLE_LAST = 3'(uv_ctrl_pkg::SETTLE_CYCLES - 1);
  localparam logic [2:0] SETTLE_DONE = 3'(uv_ctrl_pkg::SETTLE_CYCLES);
  localparam logic [2:0] UNLOCK_LOAD = 3'(uv_ctrl_pkg::UNLOCK_WINDOW);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // the hold-at-wake code behaves as continuous for the comparator
  function automatic uv_ctrl_pkg::det_mode_type run_mode(input logic [1:0] code);
    if (code == uv_ctrl_pkg::MODE_WAKE_HOLD) begin
      run_mode = uv_ctrl_pkg::MODE_CONTINUOUS;
    end else begin
      run_mode = uv_ctrl_pkg::det_mode_type'(code);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                       fuse_load_q;
  logic [2:0]                 level_q;
  logic [1:0]                 active_mode_q;
  logic [1:0]                 sleep_mode_q;
  logic                       rate_select_q;
  logic [1:0]                 margin_q;
  logic [1:0]                 trigger_q;
  logic                       irq_enable_q;
  logic                       irq_flag_q;
  logic [2:0]                 unlock_cnt_q;
  logic [7:0]                 rdata_q;
  logic [1:0]                 sync1_q;
  logic [1:0]                 sync2_q;
  uv_ctrl_pkg::seq_state_type seq_q;
  logic [CNT_W-1:0]           period_cnt_q;
  logic [2:0]                 settle_cnt_q;
  logic                       reset_req_q;
  logic                       warn_prev_q;
  logic                       warn_valid_q;

  uv_ctrl_pkg::det_mode_type  mode;
  logic                       evaluate;
  logic                       monitor_active;
  logic                       crossing;
  logic                       uv_below;
  logic                       warn_below;
  logic                       guard_write;
  logic                       mode_write;

  assign guard_write = i_reg_write && (i_reg_addr == uv_ctrl_pkg::CHANGE_GUARD_OFFSET);
  assign mode_write  = i_reg_write && (i_reg_addr == uv_ctrl_pkg::MODE_CTRL_OFFSET);

  // ----------------------------------------------------------------
  // fuse-loaded fields
  // ----------------------------------------------------------------
  // fuses are caught on the first enabled edge after reset release,
  // never through the asynchronous reset itself
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      fuse_load_q <= 1'b1;
    end else if (i_clk_en) begin
      fuse_load_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      level_q       <= uv_ctrl_pkg::LEVEL_RESET;
      active_mode_q <= uv_ctrl_pkg::MODE_RESET;
      rate_select_q <= 1'b0;
    end else if (i_clk_en && fuse_load_q) begin
      level_q       <= i_fuses.level;
      active_mode_q <= i_fuses.active_mode;
      rate_select_q <= i_fuses.sample_rate_select;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sleep_mode_q <= uv_ctrl_pkg::MODE_RESET;
    end else if (i_clk_en) begin
      if (fuse_load_q) begin
        sleep_mode_q <= i_fuses.sleep_mode;
      end else if (mode_write && (unlock_cnt_q != 3'h0) &&
                   (i_reg_wdata[uv_ctrl_pkg::SLEEP_MODE_LSB +: 2] !=
                    uv_ctrl_pkg::MODE_WAKE_HOLD)) begin
        sleep_mode_q <= i_reg_wdata[uv_ctrl_pkg::SLEEP_MODE_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // change guard
  // ----------------------------------------------------------------
  // the window counts enabled cycles, a stand-in for instructions
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      unlock_cnt_q <= 3'h0;
    end else if (i_clk_en) begin
      if (guard_write && (i_reg_wdata == UNLOCK_KEY)) begin
        unlock_cnt_q <= UNLOCK_LOAD;
      end else if (mode_write) begin
        unlock_cnt_q <= 3'h0;
      end else if (unlock_cnt_q != 3'h0) begin
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // software-owned monitor settings
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      margin_q     <= uv_ctrl_pkg::MARGIN_RESET;
      trigger_q    <= uv_ctrl_pkg::TRIGGER_RESET;
      irq_enable_q <= 1'b0;
    end else if (i_clk_en && i_reg_write) begin
      if (i_reg_addr == uv_ctrl_pkg::MONITOR_LEVEL_OFFSET) begin
        margin_q <= i_reg_wdata[1:0];
      end
      if (i_reg_addr == uv_ctrl_pkg::IRQ_CONTROL_OFFSET) begin
        trigger_q    <= i_reg_wdata[uv_ctrl_pkg::TRIGGER_LSB +: 2];
        irq_enable_q <= i_reg_wdata[uv_ctrl_pkg::IRQ_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else if (i_clk_en) begin
      sync1_q <= i_comparators;
      sync2_q <= sync1_q;
    end
  end

  assign uv_below   = sync2_q[1];
  assign warn_below = sync2_q[0];

  // ----------------------------------------------------------------
  // mode selection and sample sequencer
  // ----------------------------------------------------------------
  // deep sleep is standby or power-down; idle counts as active
  assign mode = i_deep_sleep ? run_mode(sleep_mode_q)
                             : run_mode(active_mode_q);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      seq_q        <= uv_ctrl_pkg::SEQ_WAIT;
      period_cnt_q <= '0;
      settle_cnt_q <= 3'h0;
    end else if (i_clk_en) begin
      unique case (mode)
        uv_ctrl_pkg::MODE_CONTINUOUS: begin
          seq_q        <= uv_ctrl_pkg::SEQ_SETTLE;
          period_cnt_q <= '0;
          if (settle_cnt_q < SETTLE_DONE) begin
            settle_cnt_q <= settle_cnt_q + 3'h1;
          end
        end
        uv_ctrl_pkg::MODE_SAMPLED: begin
          unique case (seq_q)
            uv_ctrl_pkg::SEQ_WAIT: begin
              settle_cnt_q <= 3'h0;
              if (period_cnt_q == '0) begin
                seq_q <= uv_ctrl_pkg::SEQ_SETTLE;
              end else begin
                period_cnt_q <= period_cnt_q - 1'b1;
              end
            end
            uv_ctrl_pkg::SEQ_SETTLE: begin
              if (settle_cnt_q >= SETTLE_LAST) begin
                seq_q        <= uv_ctrl_pkg::SEQ_WAIT;
                settle_cnt_q <= 3'h0;
                period_cnt_q <= rate_select_q ? SLOW_RELOAD : FAST_RELOAD;
              end else begin
                settle_cnt_q <= settle_cnt_q + 3'h1;
              end
            end
          endcase
        end
        default: begin
          seq_q        <= uv_ctrl_pkg::SEQ_WAIT;
          period_cnt_q <= '0;
          settle_cnt_q <= 3'h0;
        end
      endcase
    end
  end

  // comparator output is trusted only once it has settled
  assign evaluate =
    ((mode == uv_ctrl_pkg::MODE_CONTINUOUS) && (settle_cnt_q == SETTLE_DONE)) ||
    ((mode == uv_ctrl_pkg::MODE_SAMPLED) && (seq_q == uv_ctrl_pkg::SEQ_SETTLE) &&
     (settle_cnt_q == SETTLE_LAST));

  assign o_detector_power =
    (mode == uv_ctrl_pkg::MODE_CONTINUOUS) ||
    ((mode == uv_ctrl_pkg::MODE_SAMPLED) && (seq_q == uv_ctrl_pkg::SEQ_SETTLE));

  // ----------------------------------------------------------------
  // undervoltage reset request
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      reset_req_q <= 1'b0;
    end else if (i_clk_en) begin
      if (mode == uv_ctrl_pkg::MODE_DISABLED) begin
        reset_req_q <= 1'b0;
      end else if (evaluate) begin
        reset_req_q <= uv_below;
      end
    end
  end

  // ----------------------------------------------------------------
  // early-warning monitor
  // ----------------------------------------------------------------
  assign monitor_active = irq_enable_q && (mode != uv_ctrl_pkg::MODE_DISABLED);

  // the first evaluation after activation only records a baseline,
  // so enabling never fakes a crossing
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      warn_prev_q  <= 1'b0;
      warn_valid_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!monitor_active) begin
        warn_valid_q <= 1'b0;
      end else if (evaluate) begin
        warn_prev_q  <= warn_below;
        warn_valid_q <= 1'b1;
      end
    end
  end

  always_comb begin
    crossing = 1'b0;
    if (monitor_active && evaluate && warn_valid_q) begin
      unique case (uv_ctrl_pkg::trigger_type'(trigger_q))
        uv_ctrl_pkg::TRIG_FALLING: crossing = warn_below && !warn_prev_q;
        uv_ctrl_pkg::TRIG_RISING:  crossing = !warn_below && warn_prev_q;
        uv_ctrl_pkg::TRIG_EITHER:  crossing = warn_below != warn_prev_q;
        uv_ctrl_pkg::TRIG_RSVD:    crossing = 1'b0;
      endcase
    end
  end

  // a crossing in the same cycle as a clear keeps the flag set
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_flag_q <= 1'b0;
    end else if (i_clk_en) begin
      if (crossing) begin
        irq_flag_q <= 1'b1;
      end else if (i_reg_write && (i_reg_addr == uv_ctrl_pkg::IRQ_FLAG_OFFSET) &&
                   i_reg_wdata[uv_ctrl_pkg::IRQ_FLAG_BIT]) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  assign o_irq = irq_flag_q && irq_enable_q && !i_debug_halt;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_clk_en) begin
      rdata_q <= 8'h00;
      if (i_reg_read) begin
        unique case (i_reg_addr)
          uv_ctrl_pkg::MODE_CTRL_OFFSET: begin
            rdata_q[uv_ctrl_pkg::SAMPLE_RATE_BIT]      <= rate_select_q;
            rdata_q[uv_ctrl_pkg::ACTIVE_MODE_LSB +: 2] <= active_mode_q;
            rdata_q[uv_ctrl_pkg::SLEEP_MODE_LSB +: 2]  <= sleep_mode_q;
          end
          uv_ctrl_pkg::LEVEL_CTRL_OFFSET:    rdata_q[2:0] <= level_q;
          uv_ctrl_pkg::MONITOR_LEVEL_OFFSET: rdata_q[1:0] <= margin_q;
          uv_ctrl_pkg::IRQ_CONTROL_OFFSET: begin
            rdata_q[uv_ctrl_pkg::TRIGGER_LSB +: 2]  <= trigger_q;
            rdata_q[uv_ctrl_pkg::IRQ_ENABLE_BIT]    <= irq_enable_q;
          end
          uv_ctrl_pkg::IRQ_FLAG_OFFSET:
            rdata_q[uv_ctrl_pkg::IRQ_FLAG_BIT] <= irq_flag_q;
          uv_ctrl_pkg::MONITOR_STATUS_OFFSET:
            rdata_q[uv_ctrl_pkg::STATUS_BIT] <= warn_prev_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata       = rdata_q;
  assign o_reset_request   = reset_req_q;
  assign o_threshold_level = level_q;
  assign o_monitor_margin  = margin_q;

  // execution waits after wake until the comparator has settled
  assign o_wake_hold = !i_deep_sleep &&
                       (active_mode_q == uv_ctrl_pkg::MODE_WAKE_HOLD) &&
                       (settle_cnt_q != SETTLE_DONE);

endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int         FAST = 20;
  localparam int         SLOW = 40;
  localparam logic [7:0] KEY  = 8'h5A;
  logic                                i_sys_clk = 1'b0;
  logic                                i_reset = 1'b1;
  logic                                i_clk_en = 1'b1;
  logic [7:0]                          i_reg_addr = 8'h00;
  logic [7:0]                          i_reg_wdata = 8'h00;
  logic                                i_reg_write = 1'b0;
  logic                                i_reg_read = 1'b0;
  logic                                i_deep_sleep = 1'b0;
  logic                                i_debug_halt = 1'b0;
  uv_ctrl_pkg::detector_fuse_byte_type i_fuses = 8'h00;
  uv_ctrl_pkg::comparator_type         i_comparators = 2'h0;
  logic [7:0]                          o_reg_rdata;
  logic [2:0]                          o_threshold_level;
  logic [1:0]                          o_monitor_margin;
  logic                                o_detector_power, o_reset_request, o_wake_hold, o_irq;
  logic [7:0]                          rnd = 8'h1A;
  logic [1:0]                          m_sleep, m_margin, m_trig;
  logic                                m_ie, m_flag, act;
  int                                  fail_count = 0;
  int                                  compares = 0;
  int                                  k, j, n1, n2;
  // last entry is unmapped
  logic [7:0]                          addrs [6] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0A, 8'h05};

  undervoltage_mode_and_early_warning_ctrl #(
    .FAST_PERIOD_CYCLES(FAST), .SLOW_PERIOD_CYCLES(SLOW), .UNLOCK_KEY(KEY)
  ) undervoltage_mode_and_early_warning_ctrl_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_fuses(i_fuses), .i_deep_sleep(i_deep_sleep),
    .i_debug_halt(i_debug_halt), .i_comparators(i_comparators),
    .o_detector_power(o_detector_power), .o_threshold_level(o_threshold_level),
    .o_monitor_margin(o_monitor_margin), .o_reset_request(o_reset_request),
    .o_wake_hold(o_wake_hold), .o_irq(o_irq));

  always #5 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------------------------------
  // model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return {3'h0, i_fuses[7:5], m_sleep};
      8'h01: return {5'h00, i_fuses[2:0]};
      8'h08: return {6'h00, m_margin};
      8'h09: return {5'h00, m_trig, m_ie};
      8'h0A: return {7'h00, m_flag};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_read <= 1'b0;
    #1 chk(o_reg_rdata, exp_rd(a));
  endtask
  task automatic rd_all;
    foreach (addrs[i]) rd(addrs[i]);
  endtask
  task automatic setc(input logic uv, input logic warn);
    @(posedge i_sys_clk);
    i_comparators <= {uv, warn};
  endtask
  // bounded, so a dead sampling counter ends the run instead of hanging it
  task automatic wait_pow(input logic lvl, output int n);
    n = 0;
    while (o_detector_power !== lvl) begin
      @(posedge i_sys_clk);
      #1 n++;
      if (n > 2000) begin
        fail_count++;
        finish_test();
      end
    end
  endtask
  task automatic boot(input logic [7:0] f);
    // at time zero reset is already high, so the three cycles start at once
    if ($time > 0) @(posedge i_sys_clk);
    i_reset <= 1'b1;
    i_fuses <= f;
    cyc(3);
    i_reset <= 1'b0;
    cyc(2);
    m_sleep = f[4:3];
    m_margin = 2'h0;
    m_trig = 2'h0;
    m_ie = 1'b0;
    m_flag = 1'b0;
    #1 chk(o_threshold_level, f[2:0]);
  endtask
  task automatic mon(input logic [1:0] t);
    wr(8'h09, {5'h00, t, 1'b1});
    m_trig = t;
    m_ie = 1'b1;
    cyc(12);
    setc(1'b0, 1'b1);
    cyc(8);
    m_flag = act && (t == 2'h0 || t == 2'h2);
    #1 chk(o_irq, m_flag);
    setc(1'b0, 1'b0);
    cyc(8);
    m_flag = m_flag || (act && (t == 2'h1 || t == 2'h2));
    rd_all();
    @(posedge i_sys_clk);
    i_debug_halt <= 1'b1;
    #1 chk(o_irq, 1'b0);
    @(posedge i_sys_clk);
    i_debug_halt <= 1'b0;
    #1 chk(o_irq, m_flag);
    wr(8'h0A, 8'h01);
    m_flag = 1'b0;
    rd(8'h0A);
    chk(o_irq, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence: one pass per detector configuration
  // ----------------------------------------------------------------
  initial begin
    for (k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      boot({k == 4, (k == 4) ? 2'h2 : k[1:0], rnd[4:0]});
      act = (k == 1 || k == 3);
      rd_all();
      for (j = 0; j < 4; j++) begin
        rnd = lfsr(rnd);
        if (j == 0) wr(8'h01, rnd);
        if (j > 0) wr(8'h0C, KEY);
        if (j == 2) cyc(5);
        wr(8'h00, (j == 3) ? 8'hFF : {6'h3F, rnd[0], 1'b0});
        if (j == 1) m_sleep = {rnd[0], 1'b0};
        rd_all();
      end
      wr(8'h0C, KEY);
      wr(8'h00, 8'h00);
      m_sleep = 2'h0;
      for (j = 0; j < 3; j++) begin
        wr(8'h08, 8'(j));
        m_margin = 2'(j);
        #1 chk(o_monitor_margin, m_margin);
      end
      @(posedge i_sys_clk);
      i_clk_en <= 1'b0;
      wr(8'h08, 8'h00);
      i_clk_en <= 1'b1;
      rd(8'h08);
      if (k == 2 || k == 4) begin
        wait_pow(1'b0, n1);
        wait_pow(1'b1, n1);
        wait_pow(1'b0, n1);
        wait_pow(1'b1, n2);
        chk(8'(n1), 8'(uv_ctrl_pkg::SETTLE_CYCLES));
        chk(8'(n1 + n2), 8'(((k == 4) ? SLOW : FAST) + uv_ctrl_pkg::SETTLE_CYCLES));
        wr(8'h09, 8'h05);
        m_trig = 2'h2;
        m_ie = 1'b1;
        wait_pow(1'b1, n1);
        wait_pow(1'b0, n1);
        setc(1'b0, 1'b1);
        cyc(6);
        #1 chk(o_irq, 1'b0);
        wait_pow(1'b1, n1);
        wait_pow(1'b0, n1);
        m_flag = 1'b1;
        chk(o_irq, 1'b1);
        setc(1'b0, 1'b0);
      end else begin
        for (j = 0; j < 4; j++) mon(2'(j));
        setc(1'b1, 1'b0);
        cyc(8);
        #1 chk(o_reset_request, act);
        setc(1'b0, 1'b0);
        cyc(8);
        #1 chk(o_reset_request, 1'b0);
        wr(8'h09, 8'h05);
        m_trig = 2'h2;
        @(posedge i_sys_clk);
        i_deep_sleep <= 1'b1;
        #1 chk(o_detector_power, 1'b0);
        setc(1'b0, 1'b1);
        cyc(8);
        setc(1'b0, 1'b0);
        cyc(8);
        #1 chk(o_irq, 1'b0);
        @(posedge i_sys_clk);
        i_deep_sleep <= 1'b0;
        #1 chk(o_detector_power, act);
        chk(o_wake_hold, k == 3);
        cyc(12);
        #1 chk(o_wake_hold, 1'b0);
        wr(8'h0C, KEY);
        wr(8'h00, 8'h01);
        m_sleep = 2'h1;
        @(posedge i_sys_clk);
        i_deep_sleep <= 1'b1;
        #1 chk(o_detector_power, 1'b1);
        @(posedge i_sys_clk);
        i_deep_sleep <= 1'b0;
        #1 chk(o_detector_power, act);
      end
      rd_all();
      $display("configuration %0d done", k);
    end
    finish_test();
  end
endmodule

/* File: tb/uv_ctrl_properties.sv */
`timescale 1ns/1ps
module uv_ctrl_properties (
  // clock and reset
  input wire logic                                i_sys_clk,
  input wire logic                                i_reset,
  input wire logic                                i_clk_en,
  // register port
  input wire logic [7:0]                          i_reg_addr,
  input wire logic [7:0]                          i_reg_wdata,
  input wire logic                                i_reg_write,
  input wire logic                                i_reg_read,
  input wire logic [7:0]                          o_reg_rdata,
  // fuses, state and detector
  input wire uv_ctrl_pkg::detector_fuse_byte_type i_fuses,
  input wire logic                                i_debug_halt,
  input wire uv_ctrl_pkg::comparator_type         i_comparators,
  input wire logic                                o_detector_power,
  input wire logic [2:0]                          o_threshold_level,
  input wire logic [1:0]                          o_monitor_margin,
  input wire logic                                o_reset_request,
  input wire logic                                o_wake_hold,
  input wire logic                                o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_margin_write;
    i_clk_en && i_reg_write && i_reg_addr == uv_ctrl_pkg::MONITOR_LEVEL_OFFSET
      && i_reg_wdata[1:0] != 2'h3;
  endsequence
  sequence s_level_read;
    i_clk_en && i_reg_read && i_reg_addr == uv_ctrl_pkg::LEVEL_CTRL_OFFSET;
  endsequence

  a_debug_masks_irq: assert property (i_debug_halt |-> !o_irq)
    else $error("irq seen during debug halt");
  a_margin_follows: assert property (s_margin_write |=> o_monitor_margin == $past(i_reg_wdata[1:0]))
    else $error("margin select not taken from write");
  a_level_read: assert property (s_level_read |=> o_reg_rdata == {5'h00, $past(o_threshold_level)})
    else $error("level read data wrong");
  a_rdata_idle: assert property ($past(i_clk_en) && !$past(i_reg_read) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_level_from_fuse: assert property ($changed(o_threshold_level) |-> o_threshold_level == $past(i_fuses.level))
    else $error("level changed to non fuse value");
  a_irq_holds: assert property ($past(o_irq) && !$past(i_reg_write) && !i_debug_halt |-> o_irq)
    else $error("irq dropped without software write");
  a_wake_hold_ends: assert property ($rose(o_wake_hold) |-> ##[1:12] !o_wake_hold)
    else $error("wake hold never released");
  a_wake_powered: assert property (o_wake_hold |-> o_detector_power)
    else $error("wake hold with detector unpowered");
  a_reset_cause: assert property ($rose(o_reset_request) |-> $past(i_comparators.undervoltage_below, 3))
    else $error("reset request without undervoltage");
endmodule

bind undervoltage_mode_and_early_warning_ctrl uv_ctrl_properties uv_ctrl_properties_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .o_reg_rdata(o_reg_rdata), .i_fuses(i_fuses), .i_debug_halt(i_debug_halt),
  .i_comparators(i_comparators), .o_detector_power(o_detector_power),
  .o_threshold_level(o_threshold_level), .o_monitor_margin(o_monitor_margin),
  .o_reset_request(o_reset_request), .o_wake_hold(o_wake_hold), .o_irq(o_irq));
